// ===== hdl/nvm_ctl_pkg.sv
// Purpose: constants shared by the nonvolatile memory program/erase controller
// Assumes: 200 MHz system clock, 32-bit register bus, 8-bit registers in byte lane 0
// Notes: offsets are byte addresses; every register is one aligned word
package nvm_ctl_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_UNLOCK = 8'h04;
    localparam logic [7:0] OFF_ADDR_LOW = 8'h08;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h0C;
    localparam logic [7:0] OFF_DATA_LOW = 8'h10;
    localparam logic [7:0] OFF_DATA_HIGH = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    // control and status register bit positions
    localparam int BIT_RD = 0;
    localparam int BIT_WR = 1;
    localparam int BIT_PGM_EN = 2;
    localparam int BIT_ERR = 3;
    localparam int BIT_FREE = 4;
    localparam int BIT_LATCH_ONLY = 5;
    localparam int BIT_SPACE = 6;
    localparam int BIT_DONE = 0;
    // unlock key bytes
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // geometry
    localparam int ADDR_W = 15;
    localparam int DATA_W = 14;
    localparam int ROW_WORDS = 32;
    localparam int ROW_IDX_W = 5;
    localparam logic [DATA_W-1:0] LATCH_ERASED = 14'h3FFF;
    localparam logic ADDR_HIGH_TOP_READ = 1'b1;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // self-timed operation length
    localparam int CLK_PERIOD_NS = 5;
    localparam int OP_TIME_NS = 2000;
    localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // array operation codes, gray along idle-read-write path
    typedef enum logic [2:0] {
        OP_IDLE = 3'b000,
        OP_READ = 3'b001,
        OP_EE_WRITE = 3'b011,
        OP_ROW_ERASE = 3'b010,
        OP_ROW_PROG = 3'b110
    } op_t;
    // unlock progress
    typedef enum logic [1:0] {
        UL_IDLE = 2'b00,
        UL_FIRST = 2'b01,
        UL_ARMED = 2'b11
    } unlock_t;
endpackage

// ===== hdl/nvm_ctl.sv
// Purpose: program/erase/read controller for on-chip flash and eeprom, AXI4-Lite registers
// Assumes: array shows read data while arr_start stands; arr_wp is same-clock logic
// Notes: one register access counts as one instruction cycle for the unlock sequence
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
module nvm_ctl import nvm_ctl_pkg::*; #(
    parameter int OP_LEN = OP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic core_rst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic arr_start,
    output logic [2:0] arr_op,
    output logic arr_space,
    output logic [ADDR_W-1:0] arr_addr,
    output logic [DATA_W-1:0] arr_wdata,
    output logic [ROW_WORDS*DATA_W-1:0] arr_row,
    input wire logic [DATA_W-1:0] arr_rdata,
    input wire logic arr_wp,
    output logic memory_op_done_flag
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_ok;
        logic [7:0] awaddr;
        logic w_ok;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] raddr;
        logic space;
        logic latch_only;
        logic free;
        logic err;
        logic pgm_en;
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        unlock_t unlock;
        logic busy;
        logic [15:0] cnt;
        op_t op;
        logic arr_start;
        logic arr_space;
        logic [ADDR_W-1:0] arr_addr;
        logic [DATA_W-1:0] arr_wdata;
        logic [ROW_WORDS-1:0][DATA_W-1:0] latch;
        logic done;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic do_wr;
    logic do_rd;
    logic ctl_wr;
    logic start_go;
    logic latch_go;
    logic err_clr;
    logic expected;

    function automatic logic is_mapped(input logic [7:0] a);
        return a inside {OFF_CONTROL, OFF_UNLOCK, OFF_ADDR_LOW, OFF_ADDR_HIGH,
                         OFF_DATA_LOW, OFF_DATA_HIGH, OFF_STATUS};
    endfunction

    function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            OFF_CONTROL: v = {1'b0, s.space, s.latch_only, s.free, s.err, s.pgm_en,
                              s.wr, s.rd};
            OFF_ADDR_LOW: v = s.addr[7:0];
            OFF_ADDR_HIGH: v = {ADDR_HIGH_TOP_READ, s.addr[ADDR_W-1:8]};
            OFF_DATA_LOW: v = s.data[7:0];
            OFF_DATA_HIGH: v = {2'b00, s.data[DATA_W-1:8]};
            OFF_STATUS: v = {7'h00, s.done};
            default: v = 8'h00; // key register is write-only, unmapped reads zero
        endcase
        return v;
    endfunction

    // next-state logic: bus slave, unlock tracking, operation sequencing
    always_comb begin
        s_nxt = s_r;
        s_nxt.arr_start = 1'b0;
        start_go = 1'b0;
        latch_go = 1'b0;
        err_clr = 1'b0;
        expected = 1'b0;
        // channel handshakes; address and data may arrive in either order
        if (awvalid && s_r.awready) begin
            s_nxt.aw_ok = 1'b1;
            s_nxt.awaddr = awaddr;
        end
        if (wvalid && s_r.wready) begin
            s_nxt.w_ok = 1'b1;
            s_nxt.wdata = wdata[7:0];
            s_nxt.wstrb0 = wstrb[0];
        end
        if (bready && s_r.bvalid) begin
            s_nxt.bvalid = 1'b0;
        end
        if (rready && s_r.rvalid) begin
            s_nxt.rvalid = 1'b0;
        end
        do_wr = s_r.aw_ok && s_r.w_ok && !s_r.bvalid;
        do_rd = arvalid && s_r.arready;
        ctl_wr = do_wr && s_r.wstrb0 && s_r.awaddr == OFF_CONTROL;

        // unlock tracking: each access is one step, anything off-sequence drops it
        if (do_wr || do_rd) begin
            expected = !do_rd && do_wr && s_r.wstrb0 &&
                ((s_r.unlock == UL_FIRST && s_r.awaddr == OFF_UNLOCK &&
                  s_r.wdata == KEY_SECOND) ||
                 (s_r.unlock == UL_ARMED && s_r.awaddr == OFF_CONTROL));
            if (!do_rd && do_wr && s_r.wstrb0 && s_r.awaddr == OFF_UNLOCK &&
                s_r.wdata == KEY_FIRST) begin
                s_nxt.unlock = UL_FIRST;
            end else if (expected && s_r.unlock == UL_FIRST) begin
                s_nxt.unlock = UL_ARMED;
            end else begin
                s_nxt.unlock = UL_IDLE;
            end
        end

        // register writes; narrow registers live in byte lane 0
        if (do_wr) begin
            s_nxt.aw_ok = 1'b0;
            s_nxt.w_ok = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = is_mapped(s_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (s_r.wstrb0) begin
                unique case (s_r.awaddr)
                    OFF_CONTROL: begin
                        s_nxt.space = s_r.wdata[BIT_SPACE];
                        s_nxt.latch_only = s_r.wdata[BIT_LATCH_ONLY];
                        s_nxt.free = s_r.wdata[BIT_FREE];
                        s_nxt.pgm_en = s_r.wdata[BIT_PGM_EN];
                        s_nxt.err = s_r.wdata[BIT_ERR];
                        err_clr = !s_r.wdata[BIT_ERR];
                        // read bit can only be set; read refused while busy
                        if (s_r.wdata[BIT_RD] && !s_r.rd && !s_r.busy &&
                            !s_r.wdata[BIT_WR]) begin
                            s_nxt.rd = 1'b1;
                            s_nxt.arr_start = 1'b1;
                            s_nxt.op = OP_READ;
                            s_nxt.arr_space = s_nxt.space;
                            s_nxt.arr_addr = s_r.addr;
                        end
                    end
                    OFF_ADDR_LOW: s_nxt.addr[7:0] = s_r.wdata;
                    OFF_ADDR_HIGH: s_nxt.addr[ADDR_W-1:8] = s_r.wdata[6:0];
                    OFF_DATA_LOW: s_nxt.data[7:0] = s_r.wdata;
                    OFF_DATA_HIGH: s_nxt.data[DATA_W-1:8] = s_r.wdata[5:0];
                    OFF_STATUS: begin
                        if (s_r.wdata[BIT_DONE]) begin
                            s_nxt.done = 1'b0;
                        end
                    end
                    default: s_nxt.done = s_r.done;
                endcase
            end
        end

        // a broken unlock sequence is a fault
        if ((do_wr || do_rd) && s_r.unlock != UL_IDLE && !expected &&
            !(s_r.unlock == UL_FIRST && s_nxt.unlock == UL_FIRST)) begin
            s_nxt.err = 1'b1;
        end

        // start request: only straight after the key pair, enable set, not busy
        if (ctl_wr && s_r.wdata[BIT_WR] && s_r.unlock == UL_ARMED && !s_r.busy &&
            s_nxt.pgm_en) begin
            if (!s_nxt.space && !s_nxt.free && s_nxt.latch_only) begin
                // latch load: no protection check, no array cycle, done at once
                latch_go = 1'b1;
                s_nxt.latch[s_r.addr[ROW_IDX_W-1:0]] = s_r.data;
            end else if (arr_wp) begin
                s_nxt.err = 1'b1;
            end else begin
                start_go = 1'b1;
                s_nxt.busy = 1'b1;
                s_nxt.wr = 1'b1;
                s_nxt.cnt = 16'(OP_LEN - 1);
                s_nxt.arr_start = 1'b1;
                s_nxt.arr_space = s_nxt.space;
                s_nxt.arr_addr = s_r.addr;
                s_nxt.arr_wdata = s_r.data;
                if (s_nxt.space) begin
                    s_nxt.op = OP_EE_WRITE;
                end else if (s_nxt.free) begin
                    s_nxt.op = OP_ROW_ERASE;
                end else begin
                    s_nxt.op = OP_ROW_PROG;
                end
            end
        end

        // read answer is taken while the strobe stands
        if (s_r.rd) begin
            s_nxt.rd = 1'b0;
            s_nxt.op = OP_IDLE;
            s_nxt.data[7:0] = arr_rdata[7:0];
            if (!s_r.arr_space) begin
                s_nxt.data[DATA_W-1:8] = arr_rdata[DATA_W-1:8];
            end
        end

        // self-timed countdown; a zero written to the start bit is not looked at
        if (s_r.busy) begin
            s_nxt.wr = 1'b1;
            if (s_r.cnt == 16'h0000) begin
                s_nxt.busy = 1'b0;
                s_nxt.wr = 1'b0;
                s_nxt.free = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.op = OP_IDLE;
                if (s_r.op == OP_ROW_PROG) begin
                    for (int i = 0; i < ROW_WORDS; i++) begin
                        s_nxt.latch[i] = LATCH_ERASED;
                    end
                end
            end else begin
                s_nxt.cnt = s_r.cnt - 16'h0001;
            end
        end

        // register reads answer one cycle after the address is taken
        if (do_rd) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.raddr = araddr;
            s_nxt.rdata = reg_read(s_r, araddr);
            s_nxt.rresp = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        // core reset: an operation it cuts short leaves the fault flag behind
        if (core_rst) begin
            if (s_r.busy) begin
                s_nxt.err = 1'b1;
            end
            s_nxt.busy = 1'b0;
            s_nxt.wr = 1'b0;
            s_nxt.rd = 1'b0;
            s_nxt.free = 1'b0;
            s_nxt.latch_only = 1'b0;
            s_nxt.space = 1'b0;
            s_nxt.pgm_en = 1'b0;
            s_nxt.unlock = UL_IDLE;
            s_nxt.op = OP_IDLE;
            s_nxt.arr_start = 1'b0;
        end

        // ready lines registered so every output comes from a flop
        s_nxt.awready = !s_nxt.aw_ok;
        s_nxt.wready = !s_nxt.w_ok;
        s_nxt.arready = !s_nxt.rvalid;

        if (sys_rst) begin
            s_nxt = '0;
            s_nxt.unlock = UL_IDLE;
            s_nxt.op = OP_IDLE;
            s_nxt.latch = {ROW_WORDS{LATCH_ERASED}};
        end
    end

    // fault flag just keeps its old value during an operation, which is one legal reading
    always_ff @(posedge clk_sys) begin
        s_r <= s_nxt;
    end

    assign awready = s_r.awready;
    assign wready = s_r.wready;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = s_r.arready;
    assign rvalid = s_r.rvalid;
    assign rdata = {24'h000000, s_r.rdata};
    assign rresp = s_r.rresp;
    assign arr_start = s_r.arr_start;
    assign arr_op = s_r.op;
    assign arr_space = s_r.arr_space;
    assign arr_addr = s_r.arr_addr;
    assign arr_wdata = s_r.arr_wdata;
    assign arr_row = s_r.latch;
    assign memory_op_done_flag = s_r.done;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    wr_self_clear_a: assert property (s_r.busy && s_r.cnt == 16'h0000 && !core_rst |=>
        !s_r.wr && !s_r.busy && s_r.done) else $error("start bit did not self-clear");
    no_abort_a: assert property (s_r.busy && s_r.cnt != 16'h0000 && !core_rst |=>
        s_r.busy && s_r.wr) else $error("operation aborted early");
    unlock_gate_a: assert property ($rose(s_r.busy) |->
        $past(s_r.unlock) == UL_ARMED) else $error("start without unlock");
    enable_gate_a: assert property ($rose(s_r.busy) |-> s_r.pgm_en
        && s_r.arr_start) else $error("start while disabled");
    read_one_cycle_a: assert property ($rose(s_r.rd) |=> !s_r.rd)
        else $error("read bit stuck");
    ee_read_high_a: assert property (s_r.rd && s_r.arr_space && !sys_rst |=>
        $stable(s_r.data[DATA_W-1:8])) else $error("eeprom read touched high byte");
    ctl_top_zero_a: assert property (s_r.rvalid && s_r.raddr == OFF_CONTROL |->
        !s_r.rdata[7]) else $error("control bit 7 not zero");
    protect_refuse_a: assert property (start_go |-> !arr_wp)
        else $error("protected address started");
    latch_quiet_a: assert property (latch_go && !core_rst |=>
        !s_r.arr_start && !s_r.busy) else $error("latch load touched array");
    err_sticky_a: assert property (s_r.err && !err_clr |=> s_r.err)
        else $error("fault flag cleared by hardware");
    latch_erased_a: assert property (s_r.busy && s_r.cnt == 16'h0000 &&
        s_r.op == OP_ROW_PROG && !core_rst |=> s_r.latch[0] == LATCH_ERASED)
        else $error("latches not erased");
endmodule

// ===== test/nvm_array_model.sv
// Purpose: behavioural flash and eeprom arrays behind the controller's arr_* port
// Assumes: a read word is wanted while arr_start stands, as the controller takes it then
// Notes: protection is a threshold on the address the bench last wrote to the address registers
`timescale 1ns/100ps
module nvm_array_model import nvm_ctl_pkg::*; #(
    parameter logic [ADDR_W-1:0] WP_BASE = 15'h6000
) (
    input wire logic clk_sys,
    input wire logic arr_start,
    input wire logic [2:0] arr_op,
    input wire logic arr_space,
    input wire logic [ADDR_W-1:0] arr_addr,
    input wire logic [DATA_W-1:0] arr_wdata,
    input wire logic [ROW_WORDS*DATA_W-1:0] arr_row,
    input wire logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] arr_rdata,
    output logic arr_wp
);
    logic [DATA_W-1:0] flash [2**ADDR_W];
    logic [DATA_W-1:0] eeprom [2**ADDR_W];
    logic [DATA_W-1:0] junk;
    int a;
    int base;
    assign arr_wp = (reg_addr >= WP_BASE);
    // both arrays start erased, so a word never written reads all ones
    initial begin
        junk = 14'h1555;
        for (int i = 0; i < 2**ADDR_W; i++) begin
            flash[i] = LATCH_ERASED;
            eeprom[i] = LATCH_ERASED;
        end
    end
    // the controller takes the word at the edge that ends its strobe, so it is shown
    // while the strobe stands; junk toggles otherwise so a late sample cannot match
    assign arr_rdata = (arr_start === 1'b1 && arr_op == OP_READ) ?
        (arr_space ? eeprom[arr_addr] : flash[arr_addr]) : junk;
    always @(posedge clk_sys) begin
        junk <= ~junk;
        a = int'(arr_addr);
        base = int'({arr_addr[ADDR_W-1:ROW_IDX_W], 5'h00});
        if (arr_start === 1'b1) begin
            case (arr_op)
                OP_EE_WRITE: eeprom[a] = arr_wdata;
                OP_ROW_ERASE: begin
                    for (int i = 0; i < ROW_WORDS; i++) flash[base + i] = LATCH_ERASED;
                end
                OP_ROW_PROG: begin
                    for (int i = 0; i < ROW_WORDS; i++) begin
                        flash[base + i] = arr_row[i*DATA_W +: DATA_W];
                    end
                end
                default: ;
            endcase
        end
    end
endmodule

// ===== test/nvm_ctl_tb.sv
// Purpose: self-checking bench for the nvm program/erase controller
// Assumes: short OP_LEN; bus master samples ready/valid at the falling edge
// Notes: expected words are kept by the bench, never read from the design
`timescale 1ns/100ps
module nvm_ctl_tb import nvm_ctl_pkg::*; ();
    localparam int OPL = 8;
    localparam logic [ADDR_W-1:0] WP_AT = 15'h6000;
    localparam logic [7:0] C_RD = 8'h01, C_WR = 8'h02, C_EN = 8'h04, C_ERR = 8'h08;
    localparam logic [7:0] C_FREE = 8'h10, C_LATCH = 8'h20, C_SP = 8'h40;
    logic clk_sys = 1'b0, sys_rst = 1'b1, core_rst = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, arr_start, arr_space, arr_wp;
    logic memory_op_done_flag;
    logic [1:0] bresp, rresp, rs_v, bs_v;
    logic [31:0] rdata, rd_v;
    logic [2:0] arr_op;
    logic [ADDR_W-1:0] arr_addr, cur_addr = '0;
    logic [DATA_W-1:0] arr_wdata, arr_rdata;
    logic [ROW_WORDS*DATA_W-1:0] arr_row;
    logic [DATA_W-1:0] dat [4];
    logic [7:0] elo;
    integer seed, fail_count = 0, n_tests = 0, n_starts = 0;

    nvm_ctl #(.OP_LEN(OPL)) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .core_rst(core_rst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .arr_start(arr_start), .arr_op(arr_op), .arr_space(arr_space),
        .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_row(arr_row), .arr_rdata(arr_rdata),
        .arr_wp(arr_wp), .memory_op_done_flag(memory_op_done_flag));
    nvm_array_model #(.WP_BASE(WP_AT)) ARR (
        .clk_sys(clk_sys), .arr_start(arr_start), .arr_op(arr_op), .arr_space(arr_space),
        .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_row(arr_row), .reg_addr(cur_addr),
        .arr_rdata(arr_rdata), .arr_wp(arr_wp));

    always #2.5 clk_sys = ~clk_sys;
    // count program/erase strobes, reads aside, to prove that refused starts reach nothing
    always @(posedge clk_sys) begin
        if (arr_start === 1'b1 && arr_op != OP_READ) n_starts <= n_starts + 1;
    end

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, seen, exp);
        end
    endtask
    task automatic timeout();
        fail_count++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        print_verdict();
    endtask
    // each channel is released at the edge after its ready was seen high
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_ok, w_ok;
        logic b_ok = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100 && !b_ok; n++) begin
            @(negedge clk_sys);
            b_ok = bvalid && !awvalid && !wvalid;
            if (b_ok) bs_v = bresp;
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            @(posedge clk_sys);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            if (b_ok) bready <= 1'b0;
        end
        if (!b_ok) timeout();
        @(posedge clk_sys);
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_ok;
        logic r_ok = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100 && !r_ok; n++) begin
            @(negedge clk_sys);
            r_ok = rvalid && !arvalid;
            d = rdata;
            r = rresp;
            ar_ok = arvalid && arready;
            @(posedge clk_sys);
            if (ar_ok) arvalid <= 1'b0;
            if (r_ok) rready <= 1'b0;
        end
        if (!r_ok) timeout();
        @(posedge clk_sys);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        check(d, exp, msg);
    endtask
    task automatic set_addr(input logic [ADDR_W-1:0] a);
        axi_wr(OFF_ADDR_LOW, a[7:0]);
        axi_wr(OFF_ADDR_HIGH, {1'b0, a[14:8]});
        cur_addr = a;
    endtask
    task automatic unlock(input logic [7:0] ctl);
        axi_wr(OFF_UNLOCK, KEY_FIRST);
        axi_wr(OFF_UNLOCK, KEY_SECOND);
        axi_wr(OFF_CONTROL, ctl);
    endtask
    task automatic wait_done();
        logic [31:0] d = 32'hFFFFFFFF;
        logic [1:0] r;
        for (int n = 0; n < 50 && d[BIT_WR] !== 1'b0; n++) axi_rd(OFF_CONTROL, d, r);
        if (d[BIT_WR] !== 1'b0) timeout();
    endtask
    task automatic read_word(input logic [ADDR_W-1:0] a, input logic [7:0] ctl,
                             input logic [DATA_W-1:0] d);
        set_addr(a);
        axi_wr(OFF_CONTROL, ctl | C_RD);
        rdc(OFF_DATA_LOW, {24'h0, d[7:0]}, "data low");
        rdc(OFF_DATA_HIGH, {26'h0, d[13:8]}, "data high");
        rdc(OFF_CONTROL, {24'h0, ctl}, "read bit self clear");
    endtask

    initial begin
        seed = 32'h159C;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rdc(OFF_CONTROL, 32'h0, "control reset");
        rdc(OFF_ADDR_HIGH, 32'h80, "addr high reset");
        axi_rd(8'h1C, rd_v, rs_v);
        check({30'h0, rs_v}, {30'h0, RESP_SLVERR}, "unmapped resp");
        axi_wr(8'h1C, 8'h00);
        check({30'h0, bs_v}, {30'h0, RESP_SLVERR}, "unmapped write resp");
        set_addr(15'h0040);
        check({30'h0, bs_v}, {30'h0, RESP_OKAY}, "write resp");
        axi_wr(OFF_CONTROL, C_EN | C_WR);
        rdc(OFF_CONTROL, {24'h0, C_EN}, "start without key");
        $display("done: reset and refused start");
        // a read between the key bytes spoils the sequence
        axi_wr(OFF_UNLOCK, KEY_FIRST);
        rdc(OFF_ADDR_LOW, 32'h40, "addr low");
        rdc(OFF_CONTROL, {24'h0, C_EN | C_ERR}, "broken unlock");
        rdc(OFF_CONTROL, {24'h0, C_EN | C_ERR}, "fault sticky");
        axi_wr(OFF_CONTROL, 8'h00);
        axi_wr(OFF_CONTROL, C_ERR);
        rdc(OFF_CONTROL, {24'h0, C_ERR}, "fault set by sw");
        axi_wr(OFF_CONTROL, C_EN);
        $display("done: fault flag");
        for (int i = 0; i < 4; i++) begin
            dat[i] = 14'($random(seed));
            set_addr(15'h0040 + 15'(i));
            axi_wr(OFF_DATA_LOW, dat[i][7:0]);
            axi_wr(OFF_DATA_HIGH, {2'b00, dat[i][13:8]});
            unlock(C_EN | C_LATCH | C_WR);
            rdc(OFF_CONTROL, {24'h0, C_EN | C_LATCH}, "latch load");
            check({18'h0, arr_row[i*DATA_W +: DATA_W]}, {18'h0, dat[i]}, "latch");
        end
        check(n_starts, 0, "latch load strobed array");
        $display("done: latch loads");
        axi_wr(OFF_CONTROL, C_EN);
        unlock(C_EN | C_WR);
        wait_done();
        check(n_starts, 1, "row program strobe");
        check({31'h0, memory_op_done_flag}, 32'h1, "done flag");
        rdc(OFF_STATUS, 32'h1, "status done");
        check(32'(arr_row == {ROW_WORDS{LATCH_ERASED}}), 32'h1, "latches erased");
        for (int i = 0; i < 5; i++) begin
            read_word(15'h0040 + 15'(i), C_EN, (i < 4) ? dat[i] : LATCH_ERASED);
        end
        axi_wr(OFF_STATUS, 8'h01);
        rdc(OFF_STATUS, 32'h0, "status clear");
        $display("done: row program");
        // writing zero to start mid-erase must not stop it
        set_addr(15'h0041);
        unlock(C_EN | C_FREE | C_WR);
        axi_wr(OFF_CONTROL, C_EN | C_FREE);
        wait_done();
        read_word(15'h0040, C_EN, LATCH_ERASED);
        read_word(15'h0043, C_EN, LATCH_ERASED);
        $display("done: row erase");
        elo = 8'($random(seed));
        set_addr(15'h0010);
        axi_wr(OFF_DATA_LOW, elo);
        unlock(C_SP | C_EN | C_WR);
        wait_done();
        axi_wr(OFF_DATA_HIGH, 8'h2A);
        read_word(15'h0010, C_SP | C_EN, {6'h2A, elo});
        read_word(15'h0010, C_EN, LATCH_ERASED);
        $display("done: eeprom");
        set_addr(WP_AT);
        unlock(C_EN | C_WR);
        rdc(OFF_CONTROL, {24'h0, C_EN | C_ERR}, "protected start");
        check(n_starts, 3, "protected strobe");
        axi_wr(OFF_CONTROL, C_EN);
        set_addr(15'h0040);
        unlock(C_WR);
        rdc(OFF_ADDR_LOW, 32'h40, "addr low");
        check(n_starts, 3, "start without enable");
        $display("done: protection and enable");
        unlock(C_EN | C_FREE | C_WR);
        core_rst <= 1'b1;
        @(posedge clk_sys);
        core_rst <= 1'b0;
        axi_rd(OFF_CONTROL, rd_v, rs_v);
        check(rd_v & 32'h0A, 32'h08, "reset abort");
        $display("done: core reset abort");
        print_verdict();
    end
endmodule
